// File: cgr_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CGR_MAP_SVH
`define CGR_MAP_SVH

// ----------------------------------------------------------------
// Device register offsets
// ----------------------------------------------------------------
`define CGR_A_SETUP   13'h000
`define CGR_A_RBSEL   13'h004
`define CGR_A_LOOP    13'h010
`define CGR_A_UPDATE  13'h232

// ----------------------------------------------------------------
// Device reset values
// ----------------------------------------------------------------
`define CGR_D_SETUP   8'h18
`define CGR_D_RBSEL   8'h00
`define CGR_D_LOOP    8'h7D

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CGR_B_OPIN    7
`define CGR_B_LSB     6
`define CGR_B_SRST    5
`define CGR_B_LONG    4
`define CGR_B_RBSEL   0
`define CGR_B_PFD     7
`define CGR_B_CUR_HI  6
`define CGR_B_CUR_LO  4
`define CGR_B_MODE_HI 3
`define CGR_B_MODE_LO 2
`define CGR_B_UPD     0
`define CGR_B_RW      15
`define CGR_B_ADR_HI  12

// ----------------------------------------------------------------
// Instruction and byte lengths
// ----------------------------------------------------------------
`define CGR_INSTR_BITS 4'hF
`define CGR_BYTE_BITS  4'h7
`define CGR_FRAME_BITS 5'h18

// ----------------------------------------------------------------
// Host register offsets
// ----------------------------------------------------------------
`define CGR_H_ADDR    4'h0
`define CGR_H_DATA    4'h1
`define CGR_H_CTRL    4'h2
`define CGR_H_STAT    4'h3
`define CGR_H_RDATA   4'h4
`define CGR_H_OPT     4'h5

// ----------------------------------------------------------------
// Serial clock timing
// ----------------------------------------------------------------
`define CGR_CLK_NS        50
`define CGR_SCLK_HALF_NS  200
`define CGR_SCLK_HALF_CYC ((`CGR_SCLK_HALF_NS + `CGR_CLK_NS - 1) / `CGR_CLK_NS)

`endif

// File: cgr_pkg.sv
// Types and helpers shared by both ends of the serial control port
`default_nettype none

package cgr_pkg;

   typedef enum logic [1:0] {
      CGR_IDLE  = 2'b00,
      CGR_INSTR = 2'b01,
      CGR_DATA  = 2'b11
   } cgr_dst_t;

   typedef enum logic [1:0] {
      CGR_HIDLE = 2'b00,
      CGR_HLOW  = 2'b01,
      CGR_HHIGH = 2'b11,
      CGR_HEND  = 2'b10
   } cgr_hst_t;

   typedef struct packed {
      logic [1:0] cs_s;
      logic [2:0] sclk_s;
      logic [1:0] din_s;
      cgr_dst_t   st;
      logic [3:0] cnt;
      logic [15:0] sh;
      logic [7:0] rxb;
      logic [7:0] tx;
      logic       rw;
      logic [12:0] addr;
      logic [7:0] r00;
      logic [7:0] r04;
      logic [7:0] buf10;
      logic [7:0] act10;
      logic       upd;
   } cgr_dev_state_t;

   typedef struct packed {
      cgr_hst_t    st;
      logic [7:0]  div;
      logic [4:0]  bits;
      logic [23:0] tx;
      logic [7:0]  rx;
      logic        rw;
      logic        sclk;
      logic        cs_n;
      logic [12:0] addr;
      logic [7:0]  data;
      logic        ext_osc;
      logic        opin;
      logic        lsb;
      logic        cleanup;
      logic [7:0]  rd_q;
   } cgr_host_state_t;

   // Setup byte with fixed long-instruction bit and mirrored low nibble
   function automatic logic [7:0] cgr_mirror(input logic [7:0] v);
      logic [3:0] hi;
      hi = {v[7:5], 1'b1};
      return {hi, hi[0], hi[1], hi[2], hi[3]};
   endfunction

endpackage

`default_nettype wire

// File: cgr_if.sv
// Serial control port wires between host controller and clock generator
`timescale 1ns/1ps
`default_nettype none

interface cgr_if;
   logic sclk;
   logic cs_n;
   logic sdio_h_o;
   logic sdio_h_oe;
   logic sdio_d_o;
   logic sdio_d_oe;
   logic sdo_d_o;
   logic sdo_d_oe;
   logic sdio;
   logic serial_out_pin;

   // Resolved pin levels, pulled high when nobody drives
   assign sdio = sdio_h_oe ? sdio_h_o : (sdio_d_oe ? sdio_d_o : 1'b1);
   assign serial_out_pin  = sdo_d_oe ? sdo_d_o : 1'b1;

   modport dev  (input sclk, cs_n, sdio, output sdio_d_o, sdio_d_oe, sdo_d_o, sdo_d_oe);
   modport host (input sdio, serial_out_pin, output sclk, cs_n, sdio_h_o, sdio_h_oe);
endinterface

`default_nettype wire

// File: cgr_dev.sv
// Clock generator end: serial port decoder and control register bank
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "cgr_map.svh"

module cgr_dev
   import cgr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   cgr_if.dev              link,
   output logic            output_pin_enable,
   output logic            lsb_first,
   output logic            soft_reset,
   output logic            phase_detector_polarity,
   output logic [2:0]      pump_current_code,
   output logic [3:0]      pump_current_steps,
   output logic [1:0]      pump_mode,
   output logic            pump_hiz,
   output logic            pump_source,
   output logic            pump_sink,
   output logic [1:0]      loop_power_mode
);

   cgr_dev_state_t s;
   cgr_dev_state_t next_s;

   // ----------------------------------------------------------------
   // Register readback
   // ----------------------------------------------------------------
   function automatic logic [7:0] rd_byte(input logic [12:0] a,
                                          input cgr_dev_state_t q);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         `CGR_A_SETUP:  v = q.r00;
         `CGR_A_RBSEL:  v = q.r04;
         `CGR_A_LOOP:   v = q.r04[`CGR_B_RBSEL] ? q.act10 : q.buf10;
         `CGR_A_UPDATE: v = {7'h00, q.upd};
         default:       v = 8'h00;
      endcase
      return v;
   endfunction

   // Next address of a multi-byte transfer
   function automatic logic [12:0] step(input logic [12:0] a, input logic lsb);
      return lsb ? a + 13'h0001 : a - 13'h0001;
   endfunction

   logic       frame;
   logic       rise;
   logic       din;
   logic       lsb;
   logic [15:0] sh_n;
   logic [7:0] rxb_n;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      // Pin synchronisers
      next_s.cs_s   = {s.cs_s[0], link.cs_n};
      next_s.sclk_s = {s.sclk_s[1:0], link.sclk};
      next_s.din_s  = {s.din_s[0], link.sdio};
      frame = ~s.cs_s[1];
      rise  = s.sclk_s[1] & ~s.sclk_s[2];
      din   = s.din_s[1];
      lsb   = s.r00[`CGR_B_LSB];
      // Shift in either order
      sh_n  = lsb ? {din, s.sh[15:1]} : {s.sh[14:0], din};
      rxb_n = lsb ? {din, s.rxb[7:1]} : {s.rxb[6:0], din};

      // Buffered loop settings go live, update bit clears itself
      if (s.upd) begin
         next_s.act10 = s.buf10;
         next_s.upd   = 1'b0;
      end

      // Serial port framing
      if (!frame) begin
         next_s.st  = CGR_IDLE;
         next_s.cnt = 4'h0;
      end else begin
         unique case (s.st)
            CGR_IDLE: begin
               next_s.st  = CGR_INSTR;
               next_s.cnt = 4'h0;
            end
            CGR_INSTR: begin
               if (rise) begin
                  next_s.sh  = sh_n;
                  next_s.cnt = s.cnt + 4'h1;
                  // 16-bit instruction only
                  if (s.cnt == `CGR_INSTR_BITS) begin
                     next_s.rw   = sh_n[`CGR_B_RW];
                     next_s.addr = sh_n[`CGR_B_ADR_HI:0];
                     next_s.cnt  = 4'h0;
                     next_s.st   = CGR_DATA;
                     next_s.tx   = rd_byte(sh_n[`CGR_B_ADR_HI:0], s);
                  end
               end
            end
            CGR_DATA: begin
               if (rise) begin
                  next_s.rxb = rxb_n;
                  next_s.cnt = s.cnt + 4'h1;
                  next_s.tx  = lsb ? {1'b0, s.tx[7:1]} : {s.tx[6:0], 1'b0};
                  if (s.cnt == `CGR_BYTE_BITS) begin
                     next_s.cnt  = 4'h0;
                     next_s.addr = step(s.addr, lsb);
                     next_s.tx   = rd_byte(step(s.addr, lsb), s);
                     if (!s.rw) begin
                        unique case (s.addr)
                           `CGR_A_SETUP: begin
                              next_s.r00 = rxb_n;
                              // Setting the reset bit reloads setup defaults
                              if (rxb_n[`CGR_B_SRST]) begin
                                 next_s.r00 = `CGR_D_SETUP;
                                 next_s.r00[`CGR_B_SRST] = 1'b1;
                              end
                           end
                           `CGR_A_RBSEL:  next_s.r04   = rxb_n;
                           `CGR_A_LOOP:   next_s.buf10 = rxb_n;
                           `CGR_A_UPDATE: next_s.upd   = rxb_n[`CGR_B_UPD];
                           default:       next_s.r04   = s.r04;
                        endcase
                     end
                  end
               end
            end
            default: next_s.st = CGR_IDLE;
         endcase
      end

      // Soft reset holds every other register at its default
      if (s.r00[`CGR_B_SRST]) begin
         next_s.r04   = `CGR_D_RBSEL;
         next_s.buf10 = `CGR_D_LOOP;
         next_s.act10 = `CGR_D_LOOP;
         next_s.upd   = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s       <= '0;
         s.cs_s  <= 2'h3;
         s.st    <= CGR_IDLE;
         s.r00   <= `CGR_D_SETUP;
         s.r04   <= `CGR_D_RBSEL;
         s.buf10 <= `CGR_D_LOOP;
         s.act10 <= `CGR_D_LOOP;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   logic drive;
   logic obit;
   assign drive = ~s.cs_s[1] & (s.st == CGR_DATA) & s.rw;
   assign obit  = s.r00[`CGR_B_LSB] ? s.tx[0] : s.tx[7];
   assign link.sdio_d_o  = obit;
   assign link.sdio_d_oe = drive & ~s.r00[`CGR_B_OPIN];
   assign link.sdo_d_o   = obit;
   assign link.sdo_d_oe  = drive & s.r00[`CGR_B_OPIN];

   // ----------------------------------------------------------------
   // Port setup outputs from the setup register, loop control outputs from the active bank
   // ----------------------------------------------------------------
   assign output_pin_enable       = s.r00[`CGR_B_OPIN];
   assign lsb_first               = s.r00[`CGR_B_LSB];
   assign soft_reset              = s.r00[`CGR_B_SRST];
   assign phase_detector_polarity = s.act10[`CGR_B_PFD];
   assign pump_current_code       = s.act10[`CGR_B_CUR_HI:`CGR_B_CUR_LO];
   // Current in units of 0.6 mA
   assign pump_current_steps      = {1'b0, pump_current_code} + 4'h1;
   assign pump_mode               = s.act10[`CGR_B_MODE_HI:`CGR_B_MODE_LO];
   assign pump_hiz                = (pump_mode == 2'b00);
   assign pump_source             = (pump_mode == 2'b01);
   assign pump_sink               = (pump_mode == 2'b10);
   assign loop_power_mode         = s.act10[1:0];

endmodule

`default_nettype wire

// File: cgr_host.sv
// Host end: serial port master with a small command register set
`timescale 1ns/1ps
`default_nettype none
`include "cgr_map.svh"

module cgr_host
   import cgr_pkg::*;
#(
   parameter int SCLK_HALF = `CGR_SCLK_HALF_CYC
)
(
   input  wire logic       clk,
   input  wire logic       rstn,
   cgr_if.host             link,
   input  wire logic [3:0] addr,
   input  wire logic [15:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [15:0]     rdata
);

   cgr_host_state_t s;
   cgr_host_state_t next_s;
   logic            busy;
   logic            din;
   logic [7:0]      wbyte;
   logic [15:0]     instr;
   logic            turn;

   assign busy = (s.st != CGR_HIDLE);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      din    = s.opin ? link.serial_out_pin : link.sdio;
      wbyte  = s.data;
      instr  = 16'h0000;
      // Register port, read data one cycle later
      next_s.rd_q = 8'h00;
      if (rd) begin
         unique case (addr)
            `CGR_H_STAT:  next_s.rd_q = {6'h00, s.cleanup, busy};
            `CGR_H_RDATA: next_s.rd_q = s.rx;
            `CGR_H_OPT:   next_s.rd_q = {7'h00, s.ext_osc};
            default:      next_s.rd_q = 8'h00;
         endcase
      end
      if (wr) begin
         unique case (addr)
            `CGR_H_ADDR: next_s.addr    = wdata[12:0];
            `CGR_H_DATA: next_s.data    = wdata[7:0];
            `CGR_H_OPT:  next_s.ext_osc = wdata[0];
            default:     next_s.ext_osc = s.ext_osc;
         endcase
      end

      // Start a frame from a command or the reset cleanup
      if (s.st == CGR_HIDLE
          && (s.cleanup || (wr && addr == `CGR_H_CTRL && wdata[1:0] != 2'b00))) begin
         next_s.rw = ~s.cleanup & wdata[1];
         if (s.cleanup) begin
            next_s.addr = `CGR_A_SETUP;
            wbyte = `CGR_D_SETUP;
            next_s.cleanup = 1'b0;
         end else if (s.addr == `CGR_A_SETUP && !next_s.rw) begin
            wbyte = cgr_mirror(s.data);
            next_s.cleanup = wbyte[`CGR_B_SRST];
         end else if (s.addr == `CGR_A_LOOP && !s.ext_osc) begin
            wbyte[`CGR_B_PFD] = 1'b0;
         end
         instr = {next_s.rw, 2'b00, next_s.addr};
         next_s.tx   = s.lsb ? {wbyte, instr} : {instr, wbyte};
         next_s.cs_n = 1'b0;
         next_s.bits = 5'h00;
         next_s.div  = 8'h00;
         next_s.st   = CGR_HLOW;
      end else begin
         next_s.div = s.div + 8'h01;
         unique case (s.st)
            CGR_HIDLE: next_s.div = 8'h00;
            CGR_HLOW: begin
               if (s.div == 8'(SCLK_HALF - 1)) begin
                  next_s.div  = 8'h00;
                  next_s.sclk = 1'b1;
                  next_s.st   = CGR_HHIGH;
                  if (s.bits >= 5'h10) begin
                     next_s.rx = s.lsb ? {din, s.rx[7:1]} : {s.rx[6:0], din};
                  end
                  next_s.bits = s.bits + 5'h01;
               end
            end
            CGR_HHIGH: begin
               if (s.div == 8'(SCLK_HALF - 1)) begin
                  next_s.div  = 8'h00;
                  next_s.sclk = 1'b0;
                  next_s.tx   = s.lsb ? {1'b0, s.tx[23:1]} : {s.tx[22:0], 1'b0};
                  next_s.st   = (s.bits == `CGR_FRAME_BITS) ? CGR_HEND : CGR_HLOW;
               end
            end
            CGR_HEND: begin
               next_s.cs_n = 1'b1;
               if (s.div == 8'(2 * SCLK_HALF - 1)) begin
                  next_s.st = CGR_HIDLE;
                  // Follow the port setup the device now holds
                  if (!s.rw && s.addr == `CGR_A_SETUP) begin
                     wbyte = (s.cleanup || s.data[`CGR_B_SRST]) ? `CGR_D_SETUP : s.data;
                     next_s.opin = wbyte[`CGR_B_OPIN];
                     next_s.lsb  = wbyte[`CGR_B_LSB];
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s      <= '0;
         s.st   <= CGR_HIDLE;
         s.cs_n <= 1'b1;
      end else begin
         s      <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Pins and register read data
   // ----------------------------------------------------------------
   assign link.sclk      = s.sclk;
   assign link.cs_n      = s.cs_n;
   assign link.sdio_h_o  = s.lsb ? s.tx[0] : s.tx[23];
   // Let go of the data pin one cycle after the last instruction rise
   assign turn           = (s.bits > 5'h10)
                           || (s.bits == 5'h10 && (s.st != CGR_HHIGH || s.div != 8'h00));
   assign link.sdio_h_oe = ~s.cs_n & ~(s.rw & ~s.opin & turn);
   assign rdata          = {8'h00, s.rd_q};

endmodule

`default_nettype wire

// File: cgr_properties.sv
// Concurrent checks on the serial control port and the device outputs
`timescale 1ns/1ps
`default_nettype none

module cgr_properties (
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       sclk,
   input wire logic       cs_n,
   input wire logic       sdio_h_oe,
   input wire logic       sdio_d_oe,
   input wire logic       sdo_d_oe,
   input wire logic       output_pin_enable,
   input wire logic       soft_reset,
   input wire logic       phase_detector_polarity,
   input wire logic [2:0] pump_current_code,
   input wire logic [3:0] pump_current_steps,
   input wire logic [1:0] pump_mode,
   input wire logic       pump_hiz,
   input wire logic       pump_source,
   input wire logic       pump_sink
);
   logic       sclk_q;
   logic [4:0] nrise;

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   // ----------------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------------
   // Counts serial clock rises inside one frame
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sclk_q <= 1'b0;
         nrise  <= 5'h00;
      end else begin
         sclk_q <= sclk;
         if (cs_n) begin
            nrise <= 5'h00;
         end else if (sclk && !sclk_q) begin
            nrise <= nrise + 5'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   opin_sdo_a: assert property (!output_pin_enable |-> !sdo_d_oe)
      else $error("serial out driven in shared pin mode");
   no_clash_a: assert property (!(sdio_h_oe && sdio_d_oe))
      else $error("both ends drive the data pin");
   opin_sdio_a: assert property (output_pin_enable |-> !sdio_d_oe)
      else $error("data pin driven by device in split mode");
   idle_quiet_a: assert property (cs_n [*4] |-> !sdio_d_oe && !sdo_d_oe)
      else $error("device drives outside a frame");
   frame_len_a: assert property ($rose(cs_n) |-> nrise == 5'h18)
      else $error("frame is not instruction plus one byte");
   pump_steps_a: assert property (
      pump_current_steps != 4'h0 && pump_current_steps - 4'h1 == {1'b0, pump_current_code})
      else $error("pump current steps off");
   pump_decode_a: assert property (
      {pump_hiz, pump_source, pump_sink} ==
      {pump_mode == 2'h0, pump_mode == 2'h1, pump_mode == 2'h2})
      else $error("pump mode decode wrong");
   reset_hold_a: assert property (soft_reset && $past(soft_reset) |->
      pump_current_code == 3'h7 && pump_mode == 2'h3 && !phase_detector_polarity)
      else $error("loop control not at default during soft reset");

   // Main scenarios reached
   cover property (sdo_d_oe);
   cover property (sdio_d_oe);
   cover property ($rose(soft_reset));
endmodule

`default_nettype wire

// File: clock_gen_config_registers_tb.sv
// Testbench driving the host command port and watching both ends
`timescale 1ns/1ps
`default_nettype none
`include "cgr_map.svh"

module clock_gen_config_registers_tb;
   import cgr_pkg::*;

   logic        clk;
   logic        rstn;
   logic [3:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic        opin, lsbf, srst, pol, hiz, src, snk;
   logic [2:0]  code;
   logic [3:0]  steps;
   logic [1:0]  pmode;
   logic [1:0]  pwr;
   logic [23:0] cap;
   logic [15:0] v;
   logic        seen_srst;
   int          bad_count;
   int          num_checks;

   cgr_if link_if();

   cgr_dev i_cgr_dev (.clk(clk), .rstn(rstn), .link(link_if), .output_pin_enable(opin),
      .lsb_first(lsbf), .soft_reset(srst), .phase_detector_polarity(pol),
      .pump_current_code(code), .pump_current_steps(steps), .pump_mode(pmode),
      .pump_hiz(hiz), .pump_source(src), .pump_sink(snk), .loop_power_mode(pwr));

   cgr_host i_cgr_host (.clk(clk), .rstn(rstn), .link(link_if), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

   cgr_properties i_cgr_properties (.clk(clk), .rstn(rstn), .sclk(link_if.sclk),
      .cs_n(link_if.cs_n), .sdio_h_oe(link_if.sdio_h_oe), .sdio_d_oe(link_if.sdio_d_oe),
      .sdo_d_oe(link_if.sdo_d_oe), .output_pin_enable(opin), .soft_reset(srst),
      .phase_detector_polarity(pol), .pump_current_code(code),
      .pump_current_steps(steps), .pump_mode(pmode), .pump_hiz(hiz),
      .pump_source(src), .pump_sink(snk));

   // ----------------------------------------------------------------
   // Clock, wire capture and watchdog
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Last 24 data pin bits seen at serial clock rises
   always @(posedge link_if.sclk) begin
      cap <= {cap[22:0], link_if.sdio};
   end

   // Remembers that the soft reset bit was ever seen set
   always @(posedge clk) begin
      if (rstn !== 1'b1) begin
         seen_srst <= 1'b0;
      end else if (srst === 1'b1) begin
         seen_srst <= 1'b1;
      end
   end

   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      give_verdict;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic hw(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic hr(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask

   // Polls status until the frame and any follow-up frame are over
   task automatic wait_idle;
      logic [15:0] s;
      s = 16'h0003;
      for (int n = 0; n < 400 && s[1:0] != 2'b00; n++) hr(`CGR_H_STAT, s);
      chk("busy", s & 16'h0003, 24'h0);
   endtask

   task automatic dwr(input logic [12:0] a, input logic [7:0] d);
      hw(`CGR_H_ADDR, {3'h0, a});
      hw(`CGR_H_DATA, {8'h00, d});
      hw(`CGR_H_CTRL, 16'h0001);
      wait_idle;
   endtask

   task automatic drd(input logic [12:0] a, output logic [15:0] d);
      hw(`CGR_H_ADDR, {3'h0, a});
      hw(`CGR_H_CTRL, 16'h0002);
      wait_idle;
      hr(`CGR_H_RDATA, d);
   endtask

   // Frame as it appears on the wire in LSB first order
   function automatic logic [23:0] lsb_frame(input logic [23:0] f);
      logic [23:0] r;
      for (int i = 0; i < 16; i++) r[23-i] = f[8+i];
      for (int i = 0; i < 8; i++) r[7-i] = f[i];
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      bad_count = 0;
      num_checks = 0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      // Defaults and buffered loop control
      drd(`CGR_A_SETUP, v);
      chk("setup", v, 24'h18);
      dwr(`CGR_A_LOOP, 8'h2C);
      chk("wire msb", cap, 24'h00102C);
      chk("code held", code, 24'h7);
      chk("power held", pwr, 24'h1);
      drd(`CGR_A_LOOP, v);
      chk("buffer", v, 24'h2C);
      dwr(`CGR_A_RBSEL, 8'h01);
      drd(`CGR_A_LOOP, v);
      chk("active", v, 24'h7D);
      dwr(`CGR_A_UPDATE, 8'h01);
      drd(`CGR_A_UPDATE, v);
      chk("update clear", v, 24'h0);
      drd(`CGR_A_LOOP, v);
      chk("active new", v, 24'h2C);
      drd(13'h0F7, v);
      chk("unmapped", v, 24'h0);
      // Every pump code and mode, polarity with and without oscillator option
      for (int i = 0; i < 8; i++) begin
         hw(`CGR_H_OPT, 16'(i % 2));
         dwr(`CGR_A_LOOP, {1'b1, 3'(i), 2'(i), 2'b00});
         dwr(`CGR_A_UPDATE, 8'h01);
         chk("polarity", pol, 24'(i % 2));
         chk("code", code, 24'(i));
         chk("steps", steps, 24'(i + 1));
         chk("power", pwr, 24'h0);
         chk("mode", {hiz, src, snk, pmode}, {2'(i) == 2'h0, 2'(i) == 2'h1,
            2'(i) == 2'h2, 2'(i)});
      end
      // Split pins and LSB first
      dwr(`CGR_A_SETUP, 8'hC0);
      chk("split", {opin, lsbf}, 24'h3);
      drd(`CGR_A_SETUP, v);
      chk("mirror", v, 24'hDB);
      drd(`CGR_A_LOOP, v);
      chk("lsb read", v, 24'hFC);
      dwr(`CGR_A_LOOP, 8'h5F);
      chk("wire lsb", cap, lsb_frame(24'h00105F));
      // Soft reset and its completion
      dwr(`CGR_A_SETUP, 8'h20);
      chk("reset seen", seen_srst, 24'h1);
      chk("reset done", {srst, opin, lsbf}, 24'h0);
      chk("code default", code, 24'h7);
      drd(`CGR_A_LOOP, v);
      chk("loop default", v, 24'h7D);
      drd(`CGR_A_SETUP, v);
      chk("setup back", v, 24'h18);
      give_verdict;
   end
endmodule

`default_nettype wire
